/* bbx_pkg.sv */
/*
 * Shared constants and types of the bit-manipulation and branch executor.
 * Assumes an 8-bit core with a 16-bit program counter and byte-wide memory.
 */
package bbx_pkg;

    // opcodes with a fixed value
    localparam logic [7:0] OP_BIT_AND_CARRY = 8'h8B;
    localparam logic [7:0] OP_BIT_XOR_CARRY = 8'hAB;
    localparam logic [7:0] OP_BIT_OR_CARRY = 8'h6B;
    localparam logic [7:0] OP_CARRY_LOAD_BIT = 8'hCB;
    localparam logic [7:0] OP_MEM_BIT_INVERT = 8'h4B;
    localparam logic [7:0] OP_CARRY_STORE_BIT = 8'hEB;
    localparam logic [7:0] OP_BIT_TEST_DP = 8'h0C;
    localparam logic [7:0] OP_BIT_TEST_ABS = 8'h1C;
    localparam logic [7:0] OP_TEST_AND_CLEAR_MEM = 8'h5C;
    localparam logic [7:0] OP_TEST_AND_SET_MEM = 8'h3C;
    localparam logic [7:0] OP_ACC_BIT_CLEAR = 8'h2B;
    localparam logic [7:0] OP_ACC_BIT_SET = 8'h0B;
    localparam logic [7:0] OP_CARRY_CLEAR = 8'h20;
    localparam logic [7:0] OP_CARRY_SET = 8'hA0;
    localparam logic [7:0] OP_PAGE_FLAG_CLEAR = 8'h40;
    localparam logic [7:0] OP_PAGE_FLAG_SET = 8'hC0;
    localparam logic [7:0] OP_OVERFLOW_CLEAR = 8'h80;
    localparam logic [7:0] OP_BRANCH_CARRY_LOW = 8'h50;
    localparam logic [7:0] OP_BRANCH_CARRY_HIGH = 8'hD0;
    localparam logic [7:0] OP_BRANCH_ZERO_HIGH = 8'hF0;
    localparam logic [7:0] OP_BRANCH_ZERO_LOW = 8'h70;
    localparam logic [7:0] OP_BRANCH_NEGATIVE = 8'h90;
    localparam logic [7:0] OP_BRANCH_POSITIVE = 8'h10;
    localparam logic [7:0] OP_BRANCH_OVERFLOW_LOW = 8'h30;
    localparam logic [7:0] OP_BRANCH_OVERFLOW_HIGH = 8'hB0;

    // low nibbles of the bit-numbered opcode families
    localparam logic [3:0] LO_MEM_BIT = 4'h1;
    localparam logic [3:0] LO_BR_ACC = 4'h2;
    localparam logic [3:0] LO_BR_DP = 4'h3;

    // instruction lengths in bytes
    localparam logic [1:0] LEN_B1 = 2'h1;
    localparam logic [1:0] LEN_B2 = 2'h2;
    localparam logic [1:0] LEN_B3 = 2'h3;

    // cycle counts, short form is the not-taken count of a branch
    localparam logic [2:0] CYC_ILLEGAL = 3'h2;
    localparam logic [2:0] CYC_AND_CARRY = 3'h4;
    localparam logic [2:0] CYC_XOR_CARRY = 3'h5;
    localparam logic [2:0] CYC_OR_CARRY = 3'h5;
    localparam logic [2:0] CYC_LOAD_CARRY = 3'h4;
    localparam logic [2:0] CYC_BIT_INVERT = 3'h5;
    localparam logic [2:0] CYC_STORE_CARRY = 3'h6;
    localparam logic [2:0] CYC_BIT_TEST_DP = 3'h4;
    localparam logic [2:0] CYC_BIT_TEST_ABS = 3'h5;
    localparam logic [2:0] CYC_TEST_MEM = 3'h6;
    localparam logic [2:0] CYC_MEM_BIT = 3'h4;
    localparam logic [2:0] CYC_ACC_BIT = 3'h2;
    localparam logic [2:0] CYC_FLAG_OP = 3'h2;
    localparam logic [2:0] CYC_BRF_S = 3'h2;
    localparam logic [2:0] CYC_BRF_L = 3'h4;
    localparam logic [2:0] CYC_BBA_S = 3'h4;
    localparam logic [2:0] CYC_BBA_L = 3'h6;
    localparam logic [2:0] CYC_BBM_S = 3'h5;
    localparam logic [2:0] CYC_BBM_L = 3'h7;

    // sequence points inside an instruction
    localparam logic [2:0] RD_CYCLE = 3'h1;
    localparam logic [2:0] DATA_CYCLE = 3'h2;

    // direct page upper address bits above the page flag
    localparam logic [6:0] DP_PAGE_HI = 7'h00;

    // register map, fields and reset values
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_TAKEN_BIT = 1;
    localparam int ST_ILLEGAL_BIT = 2;

    // addressing modes
    localparam logic [1:0] AM_NONE = 2'h0;
    localparam logic [1:0] AM_BIT = 2'h1;
    localparam logic [1:0] AM_ABS = 2'h2;
    localparam logic [1:0] AM_DP = 2'h3;

    typedef struct packed {
        logic n, v, g, b, h, i, z, c;
    } bbx_flags_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [15:0] pc;
    } bbx_ins_t;

    typedef struct packed {
        logic done;
        logic illegal;
        logic taken;
        logic acc_we;
        logic [7:0] acc;
        logic flags_we;
        bbx_flags_t flags;
        logic [15:0] pc;
    } bbx_res_t;

    typedef enum logic [4:0] {
        K_ILL = 5'h00, K_CAND = 5'h01, K_CXOR = 5'h02, K_COR = 5'h03,
        K_CLD = 5'h04, K_MINV = 5'h05, K_CST = 5'h06, K_BITT = 5'h07,
        K_TCLR = 5'h08, K_TSET = 5'h09, K_MCLR = 5'h0A, K_MSET = 5'h0B,
        K_ACLR = 5'h0C, K_ASET = 5'h0D, K_FLAG = 5'h0E, K_BRF = 5'h0F,
        K_BBA = 5'h10, K_BBM = 5'h11
    } bbx_kind_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } bbx_state_t;

endpackage

/* bbx_exec.sv */
/*
 * Decode and execution of the bit-manipulation and conditional branch group.
 * Assumes the core offers one instruction at a time with its operand bytes,
 * and a data memory answering a read in the following cycle.
 */
// What this block does
// - bit AND carry sets carry to carry and bit, four cycles, three bytes.
// - bit test sets Z from A and M, N from M7, V from M6.
// - direct page bit clear and set force one bit, four cycles, flags kept.
// - accumulator bit clear and set force one bit, two cycles, flags kept.
// - one-byte flag ops clear or set carry and page flag, clear overflow.
// - bit XOR carry sets carry to carry xor bit, five cycles.
// - load carry copies the bit or its complement into carry.
// - bit invert flips the memory bit in place, five cycles, flags kept.
// - bit OR carry sets carry to carry or bit, five cycles.
// - store carry writes carry into the memory bit, six cycles.
// - test and clear sets N, Z from A minus M, writes M and not A.
// - test and set sets N, Z from A minus M, writes M or A.
// - branch on bit low jumps when the tested bit is zero.
// - branch on bit high jumps when the tested bit is one.
// - carry branches are two bytes, two cycles or four when taken.
// - zero flag branches are two bytes, two cycles or four when taken.
// - sign branches are two bytes, two cycles or four when taken.
// - overflow low branch jumps only while V is zero.
// - overflow high branch jumps only while V is one.
`timescale 1ns/100ps

module bbx_exec
    import bbx_pkg::*;
#(
    parameter int SEL_POS = 12,
    parameter int BITNO_LSB = 13,
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // instruction request
    input wire logic ins_valid,
    input wire bbx_ins_t ins,
    output logic ins_ready,
    // core state at issue
    input wire logic [7:0] acc_now,
    input wire bbx_flags_t flags_now,
    // result to the core
    output bbx_res_t result,
    // data memory
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    bbx_state_t state_r;
    bbx_ins_t ins_r;
    bbx_flags_t flg_r;
    bbx_flags_t flg_nxt;
    bbx_kind_t kind;
    logic [7:0] acc_r;
    logic [7:0] m_r;
    logic [2:0] cnt_r;
    logic en_r;
    logic taken_last_r;
    logic ill_last_r;
    logic [1:0] len;
    logic [1:0] amode;
    logic [2:0] cyc_s;
    logic [2:0] cyc_l;
    logic [2:0] fin;
    logic [2:0] bitno;
    logic [15:0] opw;
    logic [7:0] mask;
    logic [7:0] rel;
    logic [7:0] diff;
    logic [7:0] wr_byte;
    logic [7:0] acc_nxt;
    logic [15:0] pc_seq;
    logic [15:0] pc_nxt;
    logic inv_sel;
    logic mb;
    logic taken;
    logic wr_need;
    logic acc_we;
    logic flg_we;
    logic start;
    logic last;
    logic run;

    // request handshake
    assign run = (state_r == ST_RUN);
    assign ins_ready = !run && en_r;
    assign start = ins_valid && ins_ready;

    // operand word and bit selection
    assign opw = {ins_r.op2, ins_r.op1};
    assign inv_sel = opw[SEL_POS];
    assign mask = 8'h01 << bitno;
    assign diff = acc_r - m_r;

    // bit number comes from the operand word, the first operand byte or the opcode
    always_comb begin
        if (amode == AM_BIT) begin
            bitno = opw[BITNO_LSB +: 3];
        end else if (kind == K_ACLR || kind == K_ASET) begin
            bitno = ins_r.op1[2:0];
        end else begin
            bitno = ins_r.opcode[7:5];
        end
    end

    // opcode decode: kind, length, cycle counts, addressing
    always_comb begin
        kind = K_ILL;
        len = LEN_B1;
        cyc_s = CYC_ILLEGAL;
        cyc_l = CYC_ILLEGAL;
        amode = AM_NONE;
        if (ins_r.opcode[3:0] == LO_MEM_BIT) begin
            kind = ins_r.opcode[4] ? K_MCLR : K_MSET;
            len = LEN_B2;
            cyc_s = CYC_MEM_BIT;
            amode = AM_DP;
        end else if (ins_r.opcode[3:0] == LO_BR_ACC) begin
            kind = K_BBA;
            len = LEN_B2;
            cyc_s = CYC_BBA_S;
            cyc_l = CYC_BBA_L;
        end else if (ins_r.opcode[3:0] == LO_BR_DP) begin
            kind = K_BBM;
            len = LEN_B3;
            cyc_s = CYC_BBM_S;
            cyc_l = CYC_BBM_L;
            amode = AM_DP;
        end else begin
            unique case (ins_r.opcode)
                OP_BIT_AND_CARRY: begin
                    kind = K_CAND;
                    len = LEN_B3;
                    cyc_s = CYC_AND_CARRY;
                    amode = AM_BIT;
                end
                OP_BIT_XOR_CARRY: begin
                    kind = K_CXOR;
                    len = LEN_B3;
                    cyc_s = CYC_XOR_CARRY;
                    amode = AM_BIT;
                end
                OP_BIT_OR_CARRY: begin
                    kind = K_COR;
                    len = LEN_B3;
                    cyc_s = CYC_OR_CARRY;
                    amode = AM_BIT;
                end
                OP_CARRY_LOAD_BIT: begin
                    kind = K_CLD;
                    len = LEN_B3;
                    cyc_s = CYC_LOAD_CARRY;
                    amode = AM_BIT;
                end
                OP_MEM_BIT_INVERT: begin
                    kind = K_MINV;
                    len = LEN_B3;
                    cyc_s = CYC_BIT_INVERT;
                    amode = AM_BIT;
                end
                OP_CARRY_STORE_BIT: begin
                    kind = K_CST;
                    len = LEN_B3;
                    cyc_s = CYC_STORE_CARRY;
                    amode = AM_BIT;
                end
                OP_BIT_TEST_DP: begin
                    kind = K_BITT;
                    len = LEN_B2;
                    cyc_s = CYC_BIT_TEST_DP;
                    amode = AM_DP;
                end
                OP_BIT_TEST_ABS: begin
                    kind = K_BITT;
                    len = LEN_B3;
                    cyc_s = CYC_BIT_TEST_ABS;
                    amode = AM_ABS;
                end
                OP_TEST_AND_CLEAR_MEM: begin
                    kind = K_TCLR;
                    len = LEN_B3;
                    cyc_s = CYC_TEST_MEM;
                    amode = AM_ABS;
                end
                OP_TEST_AND_SET_MEM: begin
                    kind = K_TSET;
                    len = LEN_B3;
                    cyc_s = CYC_TEST_MEM;
                    amode = AM_ABS;
                end
                OP_ACC_BIT_CLEAR, OP_ACC_BIT_SET: begin
                    kind = (ins_r.opcode == OP_ACC_BIT_SET) ? K_ASET : K_ACLR;
                    len = LEN_B2;
                    cyc_s = CYC_ACC_BIT;
                end
                OP_CARRY_CLEAR, OP_CARRY_SET, OP_PAGE_FLAG_CLEAR,
                OP_PAGE_FLAG_SET, OP_OVERFLOW_CLEAR: begin
                    kind = K_FLAG;
                    cyc_s = CYC_FLAG_OP;
                end
                OP_BRANCH_CARRY_LOW, OP_BRANCH_CARRY_HIGH,
                OP_BRANCH_ZERO_HIGH, OP_BRANCH_ZERO_LOW,
                OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE,
                OP_BRANCH_OVERFLOW_LOW, OP_BRANCH_OVERFLOW_HIGH: begin
                    kind = K_BRF;
                    len = LEN_B2;
                    cyc_s = CYC_BRF_S;
                    cyc_l = CYC_BRF_L;
                end
                default: begin
                    kind = K_ILL;
                end
            endcase
        end
    end

    // memory address for the operand byte, page flag picks the direct page
    always_comb begin
        unique case (amode)
            AM_BIT: mem_addr = 16'(opw[ADDR_W-1:0]);
            AM_ABS: mem_addr = opw;
            AM_DP: mem_addr = {DP_PAGE_HI, flg_r.g, ins_r.op1};
            AM_NONE: mem_addr = 16'h0000;
        endcase
    end
    assign mem_rd = run && (cnt_r == RD_CYCLE) && (amode != AM_NONE);

    // branch condition, bit branches test polarity from opcode bit 4
    always_comb begin
        taken = 1'b0;
        unique case (kind)
            K_BBA: taken = (acc_r[bitno] == !ins_r.opcode[4]);
            K_BBM: taken = (m_r[bitno] == !ins_r.opcode[4]);
            K_BRF: begin
                unique case (ins_r.opcode)
                    OP_BRANCH_CARRY_LOW: taken = !flg_r.c;
                    OP_BRANCH_CARRY_HIGH: taken = flg_r.c;
                    OP_BRANCH_ZERO_HIGH: taken = flg_r.z;
                    OP_BRANCH_ZERO_LOW: taken = !flg_r.z;
                    OP_BRANCH_NEGATIVE: taken = flg_r.n;
                    OP_BRANCH_POSITIVE: taken = !flg_r.n;
                    OP_BRANCH_OVERFLOW_LOW: taken = !flg_r.v;
                    OP_BRANCH_OVERFLOW_HIGH: taken = flg_r.v;
                    default: taken = 1'b0;
                endcase
            end
            default: taken = 1'b0;
        endcase
    end

    // last cycle of the instruction, long count only when taken
    assign fin = (taken ? cyc_l : cyc_s) - 3'h1;
    assign last = run && (cnt_r == fin);

    // signed offset on the following address
    assign rel = (kind == K_BBM) ? ins_r.op2 : ins_r.op1;
    assign pc_seq = ins_r.pc + 16'(len);
    assign pc_nxt = taken ? pc_seq + {{8{rel[7]}}, rel} : pc_seq;

    // byte written back, formed from the read data as it arrives
    always_comb begin
        wr_need = 1'b1;
        wr_byte = mem_rdata;
        unique case (kind)
            K_MINV: wr_byte = mem_rdata ^ mask;
            K_CST: wr_byte = flg_r.c ? (mem_rdata | mask) : (mem_rdata & ~mask);
            K_TCLR: wr_byte = mem_rdata & ~acc_r;
            K_TSET: wr_byte = mem_rdata | acc_r;
            K_MCLR: wr_byte = mem_rdata & ~mask;
            K_MSET: wr_byte = mem_rdata | mask;
            default: wr_need = 1'b0;
        endcase
    end

    // flag and accumulator results
    always_comb begin
        flg_nxt = flg_r;
        acc_nxt = acc_r;
        flg_we = 1'b0;
        acc_we = 1'b0;
        mb = m_r[bitno] ^ inv_sel;
        unique case (kind)
            K_CAND: begin
                flg_nxt.c = flg_r.c & mb;
                flg_we = 1'b1;
            end
            K_CXOR: begin
                flg_nxt.c = flg_r.c ^ mb;
                flg_we = 1'b1;
            end
            K_COR: begin
                flg_nxt.c = flg_r.c | mb;
                flg_we = 1'b1;
            end
            K_CLD: begin
                flg_nxt.c = mb;
                flg_we = 1'b1;
            end
            K_BITT: begin
                flg_nxt.z = ((acc_r & m_r) == 8'h00);
                flg_nxt.n = m_r[7];
                flg_nxt.v = m_r[6];
                flg_we = 1'b1;
            end
            K_TCLR, K_TSET: begin
                flg_nxt.n = diff[7];
                flg_nxt.z = (diff == 8'h00);
                flg_we = 1'b1;
            end
            K_ACLR: begin
                acc_nxt = acc_r & ~mask;
                acc_we = 1'b1;
            end
            K_ASET: begin
                acc_nxt = acc_r | mask;
                acc_we = 1'b1;
            end
            K_FLAG: begin
                flg_we = 1'b1;
                unique case (ins_r.opcode)
                    OP_CARRY_CLEAR: flg_nxt.c = 1'b0;
                    OP_CARRY_SET: flg_nxt.c = 1'b1;
                    OP_PAGE_FLAG_CLEAR: flg_nxt.g = 1'b0;
                    OP_PAGE_FLAG_SET: flg_nxt.g = 1'b1;
                    default: flg_nxt.v = 1'b0;
                endcase
            end
            default: begin
                flg_we = 1'b0;
            end
        endcase
    end

    // sequencing: cycle 0 takes the request, the count ends at fin
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
        end else if (start) begin
            state_r <= ST_RUN;
            cnt_r <= 3'h1;
        end else if (last) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
        end else if (run) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    // instruction and core state captured at issue
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ins_r <= '0;
            acc_r <= 8'h00;
            flg_r <= '0;
        end else if (start) begin
            ins_r <= ins;
            acc_r <= acc_now;
            flg_r <= flags_now;
        end
    end

    // operand byte held once read
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            m_r <= 8'h00;
        end else if (run && cnt_r == DATA_CYCLE) begin
            m_r <= mem_rdata;
        end
    end

    // write-back one cycle after the data arrives
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_wr <= run && (cnt_r == DATA_CYCLE) && wr_need;
            if (run && cnt_r == DATA_CYCLE) begin
                mem_wdata <= wr_byte;
            end
        end
    end

    // result word, done is a one-cycle pulse
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            result <= '0;
        end else if (last) begin
            result.done <= 1'b1;
            result.illegal <= (kind == K_ILL);
            result.taken <= taken;
            result.acc_we <= acc_we;
            result.acc <= acc_nxt;
            result.flags_we <= flg_we;
            result.flags <= flg_nxt;
            result.pc <= pc_nxt;
        end else begin
            result.done <= 1'b0;
            result.acc_we <= 1'b0;
            result.flags_we <= 1'b0;
        end
    end

    // status of the last instruction
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            taken_last_r <= 1'b0;
            ill_last_r <= 1'b0;
        end else if (last) begin
            taken_last_r <= taken;
            ill_last_r <= (kind == K_ILL);
        end
    end

    // control register write
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            en_r <= CTRL_EN_RST;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            en_r <= reg_wdata[CTRL_EN_BIT];
        end
    end

    // register read, data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= 8'h00;
            if (reg_rd && reg_addr == REG_CTRL) begin
                reg_rdata[CTRL_EN_BIT] <= en_r;
            end else if (reg_rd && reg_addr == REG_STATUS) begin
                reg_rdata[ST_BUSY_BIT] <= run;
                reg_rdata[ST_TAKEN_BIT] <= taken_last_r;
                reg_rdata[ST_ILLEGAL_BIT] <= ill_last_r;
            end
        end
    end

endmodule

/* bbx_exec_properties.sv */
/* port assertions for bbx_exec
   assumes one clock domain with synchronous active-low reset */
`timescale 1ns/100ps
module bbx_exec_properties
    import bbx_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // instruction side
    input wire logic ins_valid,
    input wire bbx_ins_t ins,
    input wire logic ins_ready,
    input wire bbx_flags_t flags_now,
    input wire bbx_res_t result,
    // memory side
    input wire logic mem_rd,
    input wire logic mem_wr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // an instruction is taken in this cycle
    wire logic go = ins_valid && ins_ready;
    a_busy_take: assert property (go |=> !ins_ready) else $error("ready");
    a_done_single: assert property (result.done |=> !result.done) else $error("done");
    a_read_write: assert property (mem_wr |-> $past(mem_rd, 2)) else $error("order");
    a_carry_set: assert property (go && ins.opcode == OP_CARRY_SET
        |-> ##1 !result.done ##1 result.done && result.flags.c) else $error("carry set");
    a_carry_short: assert property (go && ins.opcode == OP_BRANCH_CARRY_HIGH && !flags_now.c
        |-> ##2 result.done && !result.taken && result.pc == $past(ins.pc, 2) + 16'h0002)
        else $error("carry branch");
    a_zero_long: assert property (go && ins.opcode == OP_BRANCH_ZERO_HIGH && flags_now.z
        |=> !result.done [*3] ##1 result.done && result.taken) else $error("zero branch");
    a_set_timing: assert property (go && ins.opcode == OP_TEST_AND_SET_MEM
        |=> mem_rd ##2 mem_wr ##3 result.done) else $error("test and set");
    a_acc_set: assert property (go && ins.opcode == OP_ACC_BIT_SET
        |-> ##2 result.done && result.acc_we && !result.flags_we) else $error("acc set");
    // main scenarios reached
    c_taken: cover property (result.done && result.taken);
    c_illegal: cover property (result.done && result.illegal);
    c_write: cover property (mem_wr);
endmodule
bind bbx_exec bbx_exec_properties prop_u (.core_clk, .resetn, .ins_valid, .ins, .ins_ready,
    .flags_now, .result, .mem_rd, .mem_wr);

/* bbx_mem_model.sv */
/* data memory model facing bbx_exec
   answers a read in the next cycle, scrambles its output otherwise */
`timescale 1ns/100ps
module bbx_mem_model (
    // clock
    input wire logic core_clk,
    // access from the block
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] m [0:65535];
    initial mem_rdata = 8'h00;
    // write, read answer, inverted data outside read cycles
    always @(posedge core_clk) begin
        if (mem_wr) m[mem_addr] <= mem_wdata;
        mem_rdata <= mem_rd ? m[mem_addr] : ~mem_rdata;
    end
endmodule

/* bbx_exec_tb.sv */
/* random instruction bench for bbx_exec against a reference model
   assumes bbx_mem_model as the data memory */
`timescale 1ns/100ps
module bbx_exec_tb
    import bbx_pkg::*;
;
    logic core_clk = 1'b0, resetn = 1'b0, ins_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] acc_now = 8'h00, reg_wdata = 8'h00, mem_rdata, mem_wdata, reg_rdata;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] mem_addr;
    logic ins_ready, mem_rd, mem_wr;
    bbx_ins_t ins = '0;
    bbx_flags_t flags_now = '0;
    bbx_res_t result;
    int fails = 0, checked = 0, cyc = 0;
    logic [7:0] ops [29] = '{8'h8B, 8'hAB, 8'h6B, 8'hCB, 8'h4B, 8'hEB, 8'h0C, 8'h1C, 8'h5C,
        8'h3C, 8'h2B, 8'h0B, 8'h20, 8'hA0, 8'h40, 8'hC0, 8'h80, 8'h50, 8'hD0, 8'hF0, 8'h70,
        8'h90, 8'h10, 8'h30, 8'hB0, 8'h01, 8'h02, 8'h03, 8'h2F};
    bbx_exec dut_u (.core_clk, .resetn, .ins_valid, .ins, .ins_ready, .acc_now, .flags_now,
        .result, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);
    bbx_mem_model mem_u (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    // clock and hang limit
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checked %0d, failed %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, s);
        end
    endtask
    task automatic wr(input logic [1:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] ad, input logic [7:0] e);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, ad};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "register read");
    endtask
    // reference model of one instruction, then drive and compare
    task automatic run(input logic [7:0] op, input logic [7:0] p1, input logic [7:0] p2);
        logic [7:0] a, m, ea, em, off, d;
        logic [15:0] w, ad, pc, epc;
        logic [2:0] b;
        logic t, il, bt;
        bbx_flags_t f, ef;
        int n, en, ln;
        {a, f} = 16'($urandom);
        pc = 16'($urandom);
        w = {p2, p1};
        ad = {4'h0, w[11:0]};
        b = op[3:0] inside {4'h1, 4'h2, 4'h3} ? op[7:5] : w[15:13];
        if (op[3:0] inside {4'h1, 4'h3} || op == 8'h0C) ad = {7'h00, f.g, p1};
        if (op inside {8'h1C, 8'h5C, 8'h3C}) ad = w;
        m = mem_u.m[ad];
        bt = m[b] ^ w[12];
        d = a - m;
        {ea, ef, em, t, il} = {a, f, m, 2'b00};
        case (op)
            8'h8B: ef.c = f.c & bt;
            8'hAB: ef.c = f.c ^ bt;
            8'h6B: ef.c = f.c | bt;
            8'hCB: ef.c = bt;
            8'h4B: em[b] = ~m[b];
            8'hEB: em[b] = f.c;
            8'h0C, 8'h1C: ef = {m[7], m[6], f.g, f.b, f.h, f.i, (a & m) == 8'h00, f.c};
            8'h5C: ef = {d[7], f.v, f.g, f.b, f.h, f.i, d == 8'h00, f.c};
            8'h3C: ef = {d[7], f.v, f.g, f.b, f.h, f.i, d == 8'h00, f.c};
            8'h2B, 8'h0B: ea[p1[2:0]] = ~op[5];
            8'h20, 8'hA0: ef.c = op[7];
            8'h40, 8'hC0: ef.g = op[7];
            8'h80: ef.v = 1'b0;
            8'h50, 8'hD0: t = f.c == op[7];
            8'hF0, 8'h70: t = f.z == op[7];
            8'h90, 8'h10: t = f.n == op[7];
            8'h30, 8'hB0: t = f.v == op[7];
            default: case (op[3:0])
                4'h1: em[b] = ~op[4];
                4'h2: t = a[b] == ~op[4];
                4'h3: t = m[b] == ~op[4];
                default: il = 1'b1;
            endcase
        endcase
        if (op inside {8'h5C, 8'h3C}) em = op[6] ? (m & ~a) : (m | a);
        ln = (op inside {8'h0C, 8'h2B, 8'h0B} || op[3:0] inside {4'h1, 4'h2}) ? 2 : 3;
        if (op[3:0] == 4'h0) ln = op[4] ? 2 : 1;
        if (il) ln = 1;
        en = (op inside {8'hAB, 8'h6B, 8'h4B, 8'h1C} || op[3:0] == 4'h3) ? 5 : 4;
        if (op inside {8'hEB, 8'h5C, 8'h3C}) en = 6;
        if (op inside {8'h2B, 8'h0B} || op[3:0] == 4'h0 || il) en = 2;
        en += 2 * t;
        off = op[3:0] == 4'h3 ? p2 : p1;
        epc = pc + ln[15:0] + (t ? {{8{off[7]}}, off} : 16'h0000);
        @(posedge core_clk);
        {ins_valid, ins, acc_now, flags_now} <= {1'b1, op, p1, p2, pc, a, f};
        @(posedge core_clk);
        ins_valid <= 1'b0;
        n = 1; // the taking edge counts as cycle 0, done stands after edge N-1
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (result.done !== 1'b1 && n < 12);
        chk(n, en, "cycle count");
        chk(result.pc, epc, "next pc");
        chk({result.taken, result.illegal}, {t, il}, "taken");
        chk(result.flags_we ? result.flags : f, ef, "flags");
        chk(result.acc_we ? result.acc : a, ea, "acc");
        chk(mem_u.m[ad], em, "memory");
    endtask
    // reset, register port, then random instructions
    initial begin
        int i;
        logic [7:0] op;
        void'($urandom(15352));
        for (i = 0; i < 65536; i++) mem_u.m[i] = 8'($urandom);
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        rd(2'h0, 8'h01);
        wr(2'h0, 8'h00);
        #1 chk(ins_ready, 1'b0, "ready while disabled");
        rd(2'h3, 8'h00);
        wr(2'h0, 8'h01);
        for (i = 0; i < 400; i++) begin
            op = ops[$urandom % 29];
            if (op[3:0] inside {4'h1, 4'h2, 4'h3}) op[7:4] = 4'($urandom);
            run(op, 8'($urandom), 8'($urandom));
        end
        run(8'h2F, 8'h00, 8'h00);
        rd(2'h1, 8'h04);
        conclude();
    end
endmodule
